// ===== scd_decoder.sv
/*
 * scd_decoder: serial command byte decoder of a smart card interface.
 * assumes: serial clock, chip select, data, input clock and straps are async
 * pins sampled on sys_clk (much faster); card pins are handled outside.
 */
`timescale 1ns/1ps

//Contract
//- byte is 3-bit field plus 5-bit data
//- bytes only taken under low chip select
//- card reset follows data bit 4
//- data bits 1:0 pick card supply
//- data bits 3:2 pick card clock
//- field 110 drives card pins directly
//- field 110 needs no address match
//- field 101 writes configuration codes
//- fields 000-011 select bank slots
//- bank fields must match address straps
//- field 100 programs dedicated async card
//- field 111 still mirrors reset, readback
//- configuration commands force reset low
//- reserved codes have no effect
//- readback edge by mode, top bits hiz
//- power-on defaults as listed
module scd_decoder (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // serial port from host
   input wire logic spi_clk,
   input wire logic spi_cs_b,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe_b,
   // card side
   input wire logic clk_in,
   input wire logic card_detect_input,
   input wire logic supply_ok,
   input wire logic addr0_in,
   input wire logic addr1_in,
   input wire logic io_in,
   output logic card_reset_out,
   output logic [1:0] card_supply,
   output logic card_clock_out,
   output logic card_io_line,
   output logic aux_contact_a_addr0,
   output logic aux_contact_b_addr1,
   output logic aux_drive_b,
   output logic slow_slope_select,
   output logic fast_slope_select
);
   // three-stage samplers for every async pin
   logic [8:0] pin_in, pin_q;
   logic [2:0] smp [9];
   logic clk_q, cs_q, mosi_q, cin_q, det_q, a0_q, a1_q, io_q, pok_q;
   assign pin_in = {supply_ok, io_in, addr1_in, addr0_in, card_detect_input, clk_in, spi_mosi,
      spi_cs_b, spi_clk};
   assign {pok_q, io_q, a1_q, a0_q, det_q, cin_q, mosi_q, cs_q, clk_q} = pin_q;

   // a change counts once stages 2 and 3 agree
   function automatic logic filt(input logic [2:0] s, input logic prev);
      filt = (s[1] == s[2]) ? s[1] : prev;
   endfunction
   // upper fields have a select of their own; bank fields must match the straps
   function automatic logic slot_sel(input logic [2:0] f, input logic a1, input logic a0);
      slot_sel = f[2] || (f[1:0] == {a1, a0});
   endfunction

   // samplers start at the pin idle levels, so no false select follows reset
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < 9; i++) begin
         if (!rst_b) begin
            smp[i] <= {3{scd_pkg::PIN_IDLE[i]}};
            pin_q[i] <= scd_pkg::PIN_IDLE[i];
         end else begin
            smp[i] <= {smp[i][1:0], pin_in[i]};
            pin_q[i] <= filt(smp[i], pin_q[i]);
         end
      end
   end

   // edge detection on the filtered serial clock and input clock
   logic clk_d, cin_d, rise, fall, cin_rise;
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         {clk_d, cin_d} <= 2'h0;
      end else begin
         {clk_d, cin_d} <= {clk_q, cin_q};
      end
   end
   assign rise = clk_q & ~clk_d;
   assign fall = ~clk_q & clk_d;
   assign cin_rise = cin_q & ~cin_d;

   // shift engine, configuration and card state
   scd_pkg::scd_state_e state, next_state;
   logic [scd_pkg::BIT_CNT_W-1:0] bit_cnt, next_bit_cnt;
   logic [6:0] shreg, next_shreg;
   logic [scd_pkg::CMD_W-1:0] command_byte, next_command_byte;
   logic byte_done, next_byte_done, slope_fast, next_slope_fast;
   logic det_nc, next_det_nc, edge_normal, next_edge_normal;
   logic rst_lvl, next_rst_lvl, cclk, next_cclk;
   logic [1:0] supply, next_supply, clk_mode, next_clk_mode, div, next_div;
   logic sync_mode, next_sync_mode;
   logic [3:0] sync_pins, next_sync_pins;
   logic [7:0] tx, next_tx;
   logic miso, next_miso, miso_oe_b, next_miso_oe_b;
   logic [2:0] field;
   logic [4:0] data;
   logic addr_match, sel;

   assign field = command_byte[scd_pkg::CMD_W-1:scd_pkg::FIELD_LSB];
   assign data = command_byte[scd_pkg::DATA_W-1:0];
   assign addr_match = (field[2] == 1'b0) && (field[1:0] == {a1_q, a0_q});
   // readback: detect, io, c4/c8 straps or driven sync pins, supply monitor
   logic det_bit;
   logic [7:0] rb_byte;
   assign det_bit = edge_normal ? (det_q ^ det_nc ^ 1'b1) : det_q;
   assign rb_byte = {3'h0, det_bit, io_q, sync_mode ? sync_pins[1:0] : {a0_q, a1_q}, pok_q};
   // selected when bank slot matches or a dedicated/config/sync/reserved field
   assign sel = slot_sel(field, a1_q, a0_q);

   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_command_byte = command_byte;
      next_byte_done = 1'b0;
      next_tx = tx;
      next_miso = miso;
      next_miso_oe_b = miso_oe_b;
      case (state)
         scd_pkg::SCD_IDLE: begin
            next_miso_oe_b = 1'b1;
            next_bit_cnt = '0;
            if (!cs_q) begin
               next_state = scd_pkg::SCD_SHIFT;
               next_tx = edge_normal ? {rb_byte[6:0], 1'b0} : rb_byte;
            end
         end
         scd_pkg::SCD_SHIFT: begin
            if (cs_q) begin
               next_state = scd_pkg::SCD_IDLE; // partial bytes dropped
               next_miso_oe_b = 1'b1;
            end else begin
               if (rise) begin
                  next_shreg = {shreg[5:0], mosi_q};
                  next_bit_cnt = bit_cnt + 3'h1;
                  if (bit_cnt == scd_pkg::BIT_CNT_LAST) begin
                     next_command_byte = {shreg, mosi_q};
                     next_byte_done = 1'b1;
                  end
               end
               // out edge: rising in special mode, falling in normal
               if (edge_normal ? fall : rise) begin
                  next_miso = tx[7];
                  next_tx = {tx[6:0], 1'b0};
                  // top three bits stay undriven; the rest only from a selected part
                  next_miso_oe_b = (bit_cnt < 3'h3) || ((bit_cnt == 3'h3) ?
                     ~slot_sel(shreg[2:0], a1_q, a0_q) : miso_oe_b);
               end
            end
         end
         default: next_state = scd_pkg::SCD_IDLE;
      endcase
   end

   // command application once a byte is complete
   always_comb begin
      next_det_nc = det_nc;
      next_edge_normal = edge_normal;
      next_slope_fast = slope_fast;
      next_rst_lvl = rst_lvl;
      next_supply = supply;
      next_clk_mode = clk_mode;
      next_sync_mode = sync_mode;
      next_sync_pins = sync_pins;
      if (byte_done && sel) begin
         next_rst_lvl = data[scd_pkg::RST_BIT];
         if (field == scd_pkg::FIELD_SYNC) begin
            next_sync_mode = 1'b1;
            next_sync_pins = data[3:0];
         end else if (field == scd_pkg::FIELD_CONFIG) begin
            next_rst_lvl = 1'b0;
            case (data)
               scd_pkg::CFG_DET_NO: next_det_nc = 1'b0;
               scd_pkg::CFG_DET_NC: next_det_nc = 1'b1;
               scd_pkg::CFG_EDGE_SPECIAL: next_edge_normal = 1'b0;
               scd_pkg::CFG_EDGE_NORMAL: next_edge_normal = 1'b1;
               scd_pkg::CFG_SLOPE_SLOW: next_slope_fast = 1'b0;
               scd_pkg::CFG_SLOPE_FAST: next_slope_fast = 1'b1;
               default: next_rst_lvl = 1'b0;
            endcase
         end else if (field != scd_pkg::FIELD_RESERVED) begin
            next_sync_mode = 1'b0;
            next_supply = data[1:0];
            next_clk_mode = data[3:2];
         end
      end
   end

   // input clock divider for the card clock
   always_comb begin
      next_div = cin_rise ? div + 2'h1 : div;
      case (clk_mode)
         scd_pkg::CLK_DIV1: next_cclk = cin_q;
         scd_pkg::CLK_DIV2: next_cclk = div[0];
         scd_pkg::CLK_DIV4: next_cclk = div[1];
         default: next_cclk = 1'b0;
      endcase
      if (sync_mode) begin
         next_cclk = sync_pins[3];
      end
   end

   // register all state; power-on defaults
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state <= scd_pkg::SCD_IDLE;
         bit_cnt <= '0;
         shreg <= '0;
         command_byte <= '0;
         byte_done <= 1'b0;
         tx <= '0;
         miso <= 1'b0;
         miso_oe_b <= 1'b1;
         det_nc <= scd_pkg::RST_DET_NC;
         edge_normal <= scd_pkg::RST_EDGE_NORMAL;
         slope_fast <= scd_pkg::RST_SLOPE_FAST;
         supply <= scd_pkg::RST_SUPPLY;
         clk_mode <= scd_pkg::RST_CLK_MODE;
         rst_lvl <= 1'b0;
         sync_mode <= 1'b0;
         sync_pins <= '0;
         div <= '0;
         cclk <= 1'b0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         command_byte <= next_command_byte;
         byte_done <= next_byte_done;
         tx <= next_tx;
         miso <= next_miso;
         miso_oe_b <= next_miso_oe_b;
         det_nc <= next_det_nc;
         edge_normal <= next_edge_normal;
         slope_fast <= next_slope_fast;
         supply <= next_supply;
         clk_mode <= next_clk_mode;
         rst_lvl <= next_rst_lvl;
         sync_mode <= next_sync_mode;
         sync_pins <= next_sync_pins;
         div <= next_div;
         cclk <= next_cclk;
      end
   end

   // output flops
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         card_reset_out <= 1'b0;
         card_supply <= scd_pkg::RST_SUPPLY;
         card_clock_out <= 1'b0;
         card_io_line <= 1'b0;
         aux_contact_a_addr0 <= 1'b0;
         aux_contact_b_addr1 <= 1'b0;
         aux_drive_b <= 1'b1;
         slow_slope_select <= 1'b1;
         fast_slope_select <= 1'b0;
         spi_miso <= 1'b0;
         spi_miso_oe_b <= 1'b1;
      end else begin
         card_reset_out <= next_rst_lvl;
         card_supply <= next_supply;
         card_clock_out <= next_cclk;
         card_io_line <= next_sync_pins[2];
         aux_contact_a_addr0 <= next_sync_pins[1];
         aux_contact_b_addr1 <= next_sync_pins[0];
         aux_drive_b <= ~next_sync_mode;
         slow_slope_select <= ~next_slope_fast;
         fast_slope_select <= next_slope_fast;
         spi_miso <= next_miso;
         spi_miso_oe_b <= next_miso_oe_b;
      end
   end

   // checks
   property p_rst_follow;
      @(posedge sys_clk) disable iff (!rst_b)
      byte_done && sel && field != scd_pkg::FIELD_CONFIG |=> card_reset_out == $past(data[4]);
   endproperty
   a_rst_follow: assert property (p_rst_follow) else $error("reset not mirrored");
   property p_cfg_rst;
      @(posedge sys_clk) disable iff (!rst_b)
      byte_done && field == scd_pkg::FIELD_CONFIG |=> !card_reset_out;
   endproperty
   a_cfg_rst: assert property (p_cfg_rst) else $error("config left reset high");
   property p_supply;
      @(posedge sys_clk) disable iff (!rst_b)
      byte_done && addr_match |=> card_supply == $past(data[1:0]);
   endproperty
   a_supply: assert property (p_supply) else $error("supply not applied");
   property p_nomatch;
      @(posedge sys_clk) disable iff (!rst_b)
      byte_done && !sel |=> $stable(card_supply) && $stable(card_reset_out);
   endproperty
   a_nomatch: assert property (p_nomatch) else $error("unmatched slot acted");
   property p_cs_hold;
      @(posedge sys_clk) disable iff (!rst_b)
      cs_q |=> !byte_done;
   endproperty
   a_cs_hold: assert property (p_cs_hold) else $error("byte taken without select");
   property p_sync;
      @(posedge sys_clk) disable iff (!rst_b)
      byte_done && field == scd_pkg::FIELD_SYNC |=> card_io_line == $past(data[2]);
   endproperty
   a_sync: assert property (p_sync) else $error("sync pin not driven");
   property p_slope;
      @(posedge sys_clk) disable iff (!rst_b)
      byte_done && field == scd_pkg::FIELD_CONFIG && data == scd_pkg::CFG_SLOPE_FAST
      |=> fast_slope_select && !slow_slope_select;
   endproperty
   a_slope: assert property (p_slope) else $error("slope not set");
   property p_idle_hiz;
      @(posedge sys_clk) disable iff (!rst_b)
      state == scd_pkg::SCD_IDLE |=> ##1 spi_miso_oe_b;
   endproperty
   a_idle_hiz: assert property (p_idle_hiz) else $error("readback driven when idle");
   c_cfg: cover property (@(posedge sys_clk) byte_done && field == scd_pkg::FIELD_CONFIG);
   c_sync: cover property (@(posedge sys_clk) byte_done && field == scd_pkg::FIELD_SYNC);
   c_bank: cover property (@(posedge sys_clk) byte_done && addr_match);
endmodule

// ===== scd_host_model.sv
/*
 * scd_host_model: host side of the serial command port, sends command bytes.
 * assumes: sys_clk from the bench; spi clock halves last 8 sys_clk cycles.
 */
`timescale 1ns/1ps
module scd_host_model (
   // timing reference
   input wire logic sys_clk,
   // serial port to the decoder
   output logic spi_clk,
   output logic spi_cs_b,
   output logic spi_mosi,
   input wire logic spi_miso
);
   // readback as seen just before each rising and each falling serial clock edge
   logic [7:0] rx_rise, rx_fall;
   // idle levels: clock stands low, select released
   initial begin
      spi_clk = 1'b0;
      spi_cs_b = 1'b1;
      spi_mosi = 1'b1;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // one select frame, msb first, only the top n bits; config bytes carry bit 4 low
   task automatic send_byte(input logic [7:0] b, input int n);
      int i;
      spi_cs_b = 1'b0;
      wait_clk(8);
      for (i = 7; i > 7 - n; i--) begin
         spi_mosi = b[i];
         wait_clk(8);
         rx_rise = {rx_rise[6:0], spi_miso};
         spi_clk = 1'b1;
         wait_clk(8);
         rx_fall = {rx_fall[6:0], spi_miso};
         spi_clk = 1'b0;
      end
      // released data line shows the inverse of its last bit
      spi_mosi = ~spi_mosi;
      wait_clk(4);
      spi_cs_b = 1'b1;
      wait_clk(16);
   endtask
endmodule

// ===== scd_pkg.sv
/*
 * scd_pkg: constants for the smart card interface command decoder.
 * assumes: used by scd_decoder only; no imports, names are scoped.
 */
package scd_pkg;
   // command byte layout
   localparam int CMD_W = 8;
   localparam int FIELD_LSB = 5;
   localparam int DATA_W = 5;
   localparam int RST_BIT = 4;
   // command field codes
   localparam logic [2:0] FIELD_DEDICATED_ASYNC = 3'h4;
   localparam logic [2:0] FIELD_CONFIG = 3'h5;
   localparam logic [2:0] FIELD_SYNC = 3'h6;
   localparam logic [2:0] FIELD_RESERVED = 3'h7;
   // configuration data codes
   localparam logic [4:0] CFG_DET_NO = 5'h00;
   localparam logic [4:0] CFG_DET_NC = 5'h01;
   localparam logic [4:0] CFG_EDGE_SPECIAL = 5'h02;
   localparam logic [4:0] CFG_EDGE_NORMAL = 5'h03;
   localparam logic [4:0] CFG_SLOPE_SLOW = 5'h04;
   localparam logic [4:0] CFG_SLOPE_FAST = 5'h05;
   // card clock modes
   localparam logic [1:0] CLK_LOW = 2'h0;
   localparam logic [1:0] CLK_DIV1 = 2'h1;
   localparam logic [1:0] CLK_DIV2 = 2'h2;
   localparam logic [1:0] CLK_DIV4 = 2'h3;
   // reset values
   localparam logic [1:0] RST_SUPPLY = 2'h0;
   localparam logic [1:0] RST_CLK_MODE = 2'h0;
   localparam logic RST_DET_NC = 1'b0;
   localparam logic RST_EDGE_NORMAL = 1'b0;
   localparam logic RST_SLOPE_FAST = 1'b0;
   // sampler reset levels; bit 1 is the serial select, which idles high
   localparam logic [8:0] PIN_IDLE = 9'h002;
   localparam int BIT_CNT_W = 3;
   localparam logic [2:0] BIT_CNT_LAST = 3'h7;
   // shift states
   typedef enum logic [1:0] {
      SCD_IDLE = 2'b01,
      SCD_SHIFT = 2'b10
   } scd_state_e;
endpackage

// ===== test_scd_decoder.sv
/*
 * test_scd_decoder: self-checking bench of the command byte decoder.
 * assumes: host model drives the serial port; straps give slot 1.
 */
`timescale 1ns/1ps
module test_scd_decoder;
   logic sys_clk, rst_b, clk_in, det, sok, a0, a1, io_in;
   logic spi_clk, spi_cs_b, spi_mosi, miso, miso_oe_b, rst_o, clk_o, io_o, c4, c8;
   logic drv_b, slow, fast;
   logic [1:0] sup;
   int error_cnt = 0;
   int checks_done = 0;
   scd_decoder dut (.sys_clk(sys_clk), .rst_b(rst_b), .spi_clk(spi_clk),
      .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi), .spi_miso(miso), .spi_miso_oe_b(miso_oe_b),
      .clk_in(clk_in), .card_detect_input(det), .supply_ok(sok), .addr0_in(a0),
      .addr1_in(a1), .io_in(io_in), .card_reset_out(rst_o), .card_supply(sup),
      .card_clock_out(clk_o), .card_io_line(io_o), .aux_contact_a_addr0(c4),
      .aux_contact_b_addr1(c8), .aux_drive_b(drv_b), .slow_slope_select(slow),
      .fast_slope_select(fast));
   scd_host_model host (.sys_clk(sys_clk), .spi_clk(spi_clk), .spi_cs_b(spi_cs_b),
      .spi_mosi(spi_mosi), .spi_miso(miso));
   // compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // power-on defaults
   task automatic t_defaults();
      chk({rst_o, sup, clk_o, slow, fast, miso_oe_b}, 8'h05);
      $display("test defaults done");
   endtask
   // bank slot match and mismatch
   task automatic t_bank();
      host.send_byte(8'h37, 8);
      chk({rst_o, sup}, 8'h07);
      host.send_byte(8'h41, 8);
      chk({rst_o, sup}, 8'h07);
      $display("test bank done");
   endtask
   // dedicated async card: each clock and supply code, edges counted
   task automatic t_modes();
      int m, n, k;
      logic last;
      for (m = 0; m < 4; m++) begin
         host.send_byte({3'h4, 1'b0, m[1:0], m[1:0]}, 8);
         chk(sup, {6'h00, m[1:0]});
         n = 0;
         last = clk_o;
         for (k = 0; k < 160; k++) begin
            @(negedge sys_clk);
            if (clk_o === 1'b1 && last === 1'b0) n++;
            last = clk_o;
         end
         k = (m == 0) ? 0 : (32 >> m);
         chk(8'((n >= k - 1 && n <= k + 1) ? 1 : 0), 8'h01);
      end
      $display("test modes done");
   endtask
   // sync card pins, straps not matching
   task automatic t_sync();
      host.send_byte(8'hD6, 8);
      chk({rst_o, clk_o, io_o, c4, c8, drv_b}, 8'h2C);
      $display("test sync done");
   endtask
   // configuration codes pull reset low
   task automatic t_config();
      host.send_byte(8'h3F, 8);
      host.send_byte(8'hA5, 8);
      chk({rst_o, slow, fast, sup}, 8'h07);
      host.send_byte(8'hA4, 8);
      chk({rst_o, slow, fast}, 8'h02);
      $display("test config done");
   endtask
   // partial byte dropped by select release
   task automatic t_abort();
      host.send_byte(8'h90, 4);
      chk({rst_o, sup}, 8'h03);
      $display("test abort done");
   endtask
   // reserved field only mirrors bit 4
   task automatic t_reserved();
      host.send_byte(8'hF0, 8);
      chk({rst_o, sup, slow}, 8'h0F);
      $display("test reserved done");
   endtask
   // readback byte in special then normal edge mode, both detect polarities
   task automatic t_readback();
      host.send_byte(8'hA3, 8);
      chk({3'h0, host.rx_fall[4:0]}, 8'h1D);
      host.send_byte(8'hA1, 8);
      chk({3'h0, host.rx_rise[4:0]}, 8'h0D);
      host.send_byte(8'hA2, 8);
      chk({3'h0, host.rx_rise[4:0]}, 8'h1D);
      $display("test readback done");
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      clk_in = 1'b0;
      forever #40 clk_in = ~clk_in;
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      print_verdict();
   end
   initial begin
      rst_b = 1'b0;
      det = 1'b1;
      sok = 1'b1;
      a0 = 1'b1;
      a1 = 1'b0;
      io_in = 1'b1;
      repeat (16) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge sys_clk);
      t_defaults();
      t_bank();
      t_modes();
      t_sync();
      t_config();
      t_abort();
      t_reserved();
      t_readback();
      print_verdict();
   end
endmodule
